// ---- src/pprr_pkg.sv ----
// Package for the peripheral pin routing registers.
// Assumes a byte-wide register port clocked by the system clock.
package pprr_pkg;

  // Register offsets on the byte-wide register port.
  localparam logic [7:0] PPRR_I2C_ROUTE_OFFSET = 8'h05;
  localparam logic [7:0] PPRR_SIX_TIMER_ROUTE_OFFSET = 8'h06;
  localparam logic [7:0] PPRR_SINGLE_TIMER_ROUTE_OFFSET = 8'h07;
  localparam logic [7:0] PPRR_FOUR_TIMER_ROUTE_OFFSET = 8'h08;
  localparam logic [7:0] PPRR_COMPARATOR_ROUTE_OFFSET = 8'h09;
  localparam logic [7:0] PPRR_ZERO_CROSS_ROUTE_OFFSET = 8'h0A;

  // Reset values.
  localparam logic [7:0] PPRR_I2C_ROUTE_RESET = 8'h00;
  localparam logic [7:0] PPRR_SIX_TIMER_ROUTE_RESET = 8'h00;
  localparam logic [7:0] PPRR_SINGLE_TIMER_ROUTE_RESET = 8'h00;
  localparam logic [7:0] PPRR_FOUR_TIMER_ROUTE_RESET = 8'h00;
  localparam logic [7:0] PPRR_COMPARATOR_ROUTE_RESET = 8'h00;
  localparam logic [7:0] PPRR_ZERO_CROSS_ROUTE_RESET = 8'h00;
  localparam logic [7:0] PPRR_READ_IDLE = 8'h00;

  // Writable bits of each register; all other bits read as zero.
  localparam logic [7:0] PPRR_I2C_ROUTE_MASK = 8'h0F;
  localparam logic [7:0] PPRR_SIX_TIMER_ROUTE_MASK = 8'h3F;
  localparam logic [7:0] PPRR_SINGLE_TIMER_ROUTE_MASK = 8'h1F;
  localparam logic [7:0] PPRR_FOUR_TIMER_ROUTE_MASK = 8'h07;
  localparam logic [7:0] PPRR_COMPARATOR_ROUTE_MASK = 8'h07;
  localparam logic [7:0] PPRR_ZERO_CROSS_ROUTE_MASK = 8'h07;

  // Field positions.
  localparam int PPRR_SECOND_I2C_LSB = 2;
  localparam int PPRR_FIRST_I2C_LSB = 0;
  localparam int PPRR_SECOND_SIX_LSB = 3;
  localparam int PPRR_FIRST_SIX_LSB = 0;
  localparam int PPRR_FOUR_LSB = 0;

  // Field codes.
  localparam logic [1:0] PPRR_I2C_DEFAULT = 2'h0;
  localparam logic [1:0] PPRR_I2C_FIRST_ALTERNATE_POSITION = 2'h1;
  localparam logic [1:0] PPRR_I2C_SECOND_ALTERNATE_POSITION = 2'h2;
  localparam logic [2:0] PPRR_FIRST_SIX_LAST_CODE = 3'h6;
  localparam logic [2:0] PPRR_SECOND_SIX_PORT_B = 3'h0;
  localparam logic [2:0] PPRR_SECOND_SIX_PORT_G = 3'h3;
  localparam logic [2:0] PPRR_FOUR_LAST_CODE = 3'h3;

  typedef struct packed {
    logic [7:0] i2c_pin_route;
    logic [7:0] six_output_timer_route;
    logic [7:0] single_output_timer_route;
    logic [7:0] four_output_timer_route;
    logic [7:0] comparator_output_route;
    logic [7:0] zero_cross_output_route;
    logic [7:0] read_data;
  } pprr_state_type;

  localparam pprr_state_type PPRR_STATE_RESET = '{
    i2c_pin_route: PPRR_I2C_ROUTE_RESET,
    six_output_timer_route: PPRR_SIX_TIMER_ROUTE_RESET,
    single_output_timer_route: PPRR_SINGLE_TIMER_ROUTE_RESET,
    four_output_timer_route: PPRR_FOUR_TIMER_ROUTE_RESET,
    comparator_output_route: PPRR_COMPARATOR_ROUTE_RESET,
    zero_cross_output_route: PPRR_ZERO_CROSS_ROUTE_RESET,
    read_data: PPRR_READ_IDLE
  };

endpackage

// ---- src/pprr_peripheral_pin_route_regs.sv ----
// Pin routing registers for the peripheral units and their decoded selections.
// Assumes a same-clock register master with one-cycle strobes and a pin
// multiplexer that consumes the field and decode outputs.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps

module pprr_peripheral_pin_route_regs
  import pprr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  output logic [7:0] o_reg_rdata,
  // I2C routing.
  output logic [1:0] o_second_i2c_route_field,
  output logic [1:0] o_first_i2c_route_field,
  output logic o_second_i2c_host_alt,
  output logic o_second_i2c_client_alt,
  output logic o_second_i2c_route_valid,
  output logic o_first_i2c_host_alt,
  output logic o_first_i2c_client_alt,
  output logic o_first_i2c_route_valid,
  // Six-output timer routing.
  output logic [2:0] o_second_six_output_timer_field,
  output logic [2:0] o_first_six_output_timer_field,
  output logic [3:0] o_second_six_port_sel,
  output logic o_second_six_all_outputs,
  output logic [6:0] o_first_six_port_sel,
  // Single-output timer routing.
  output logic o_fifth_single_timer_bit,
  output logic o_fourth_single_timer_bit,
  output logic o_third_single_timer_bit,
  output logic o_second_single_timer_bit,
  output logic o_first_single_timer_bit,
  // Four-output timer routing.
  output logic [2:0] o_four_output_timer_field,
  output logic [3:0] o_four_output_port_sel,
  // Comparator and zero-cross routing.
  output logic o_third_comparator_bit,
  output logic o_second_comparator_bit,
  output logic o_first_comparator_bit,
  output logic o_third_zero_cross_bit,
  output logic o_second_zero_cross_bit,
  output logic o_first_zero_cross_bit
);
  import pprr_pkg::*;

  pprr_state_type state_q;
  pprr_state_type state_d;

  // One-hot select from a small code; zero when the code is out of range.
  function automatic logic [7:0] pprr_onehot(input logic [2:0] code, input logic [2:0] last);
    logic [7:0] sel;
    sel = 8'h00;
    if (code <= last) begin
      sel[code] = 1'b1;
    end
    return sel;
  endfunction

  // Host moves to the client pair only for the second alternate code.
  function automatic logic pprr_i2c_host_alt(input logic [1:0] code);
    return code == PPRR_I2C_SECOND_ALTERNATE_POSITION;
  endfunction

  // Client moves to the alternate pair for both alternate codes.
  function automatic logic pprr_i2c_client_alt(input logic [1:0] code);
    return (code == PPRR_I2C_FIRST_ALTERNATE_POSITION) || (code == PPRR_I2C_SECOND_ALTERNATE_POSITION);
  endfunction

  // The reserved code leaves the pins to the multiplexer's default handling.
  function automatic logic pprr_i2c_valid(input logic [1:0] code);
    return code != 2'h3;
  endfunction

  // Compare against a byte offset, widening it to the address bus.
  function automatic logic pprr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
    return addr == ADDR_W'(offset);
  endfunction

  // Writes are masked here so that the unused upper bits can never hold a one.
  always_comb begin
    state_d = state_q;
    state_d.read_data = PPRR_READ_IDLE;
    if (i_reg_write) begin
      if (pprr_hit(i_reg_addr, PPRR_I2C_ROUTE_OFFSET)) begin
        state_d.i2c_pin_route = i_reg_wdata & PPRR_I2C_ROUTE_MASK;
      end
      if (pprr_hit(i_reg_addr, PPRR_SIX_TIMER_ROUTE_OFFSET)) begin
        state_d.six_output_timer_route = i_reg_wdata & PPRR_SIX_TIMER_ROUTE_MASK;
      end
      if (pprr_hit(i_reg_addr, PPRR_SINGLE_TIMER_ROUTE_OFFSET)) begin
        state_d.single_output_timer_route = i_reg_wdata & PPRR_SINGLE_TIMER_ROUTE_MASK;
      end
      if (pprr_hit(i_reg_addr, PPRR_FOUR_TIMER_ROUTE_OFFSET)) begin
        state_d.four_output_timer_route = i_reg_wdata & PPRR_FOUR_TIMER_ROUTE_MASK;
      end
      if (pprr_hit(i_reg_addr, PPRR_COMPARATOR_ROUTE_OFFSET)) begin
        state_d.comparator_output_route = i_reg_wdata & PPRR_COMPARATOR_ROUTE_MASK;
      end
      if (pprr_hit(i_reg_addr, PPRR_ZERO_CROSS_ROUTE_OFFSET)) begin
        state_d.zero_cross_output_route = i_reg_wdata & PPRR_ZERO_CROSS_ROUTE_MASK;
      end
    end
    // Unmapped reads return zero so software sees no stale bus value.
    if (i_reg_read) begin
      if (pprr_hit(i_reg_addr, PPRR_I2C_ROUTE_OFFSET)) begin
        state_d.read_data = state_q.i2c_pin_route;
      end else if (pprr_hit(i_reg_addr, PPRR_SIX_TIMER_ROUTE_OFFSET)) begin
        state_d.read_data = state_q.six_output_timer_route;
      end else if (pprr_hit(i_reg_addr, PPRR_SINGLE_TIMER_ROUTE_OFFSET)) begin
        state_d.read_data = state_q.single_output_timer_route;
      end else if (pprr_hit(i_reg_addr, PPRR_FOUR_TIMER_ROUTE_OFFSET)) begin
        state_d.read_data = state_q.four_output_timer_route;
      end else if (pprr_hit(i_reg_addr, PPRR_COMPARATOR_ROUTE_OFFSET)) begin
        state_d.read_data = state_q.comparator_output_route;
      end else if (pprr_hit(i_reg_addr, PPRR_ZERO_CROSS_ROUTE_OFFSET)) begin
        state_d.read_data = state_q.zero_cross_output_route;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= PPRR_STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_reg_rdata = state_q.read_data;

  // The alternate client pairs use ordinary drivers, so software must keep
  // the bus to normal or fast mode there; nothing here enforces it.
  assign o_second_i2c_route_field = state_q.i2c_pin_route[PPRR_SECOND_I2C_LSB +: 2];
  assign o_first_i2c_route_field = state_q.i2c_pin_route[PPRR_FIRST_I2C_LSB +: 2];
  assign o_second_i2c_host_alt = pprr_i2c_host_alt(o_second_i2c_route_field);
  assign o_second_i2c_client_alt = pprr_i2c_client_alt(o_second_i2c_route_field);
  assign o_second_i2c_route_valid = pprr_i2c_valid(o_second_i2c_route_field);
  assign o_first_i2c_host_alt = pprr_i2c_host_alt(o_first_i2c_route_field);
  assign o_first_i2c_client_alt = pprr_i2c_client_alt(o_first_i2c_route_field);
  assign o_first_i2c_route_valid = pprr_i2c_valid(o_first_i2c_route_field);

  // Second six-output timer: bit n of the select is code n (B, C, E, G).
  assign o_second_six_output_timer_field =
    state_q.six_output_timer_route[PPRR_SECOND_SIX_LSB +: 3];
  logic [7:0] second_six_sel;
  assign second_six_sel = pprr_onehot(o_second_six_output_timer_field,
    PPRR_SECOND_SIX_PORT_G);
  assign o_second_six_port_sel = second_six_sel[3:0];
  // Ports C and E carry only outputs 0 to 2.
  assign o_second_six_all_outputs =
    (o_second_six_output_timer_field == PPRR_SECOND_SIX_PORT_B) ||
    (o_second_six_output_timer_field == PPRR_SECOND_SIX_PORT_G);

  // First six-output timer: bit n selects port A plus n.
  assign o_first_six_output_timer_field =
    state_q.six_output_timer_route[PPRR_FIRST_SIX_LSB +: 3];
  logic [7:0] first_six_sel;
  assign first_six_sel = pprr_onehot(o_first_six_output_timer_field,
    PPRR_FIRST_SIX_LAST_CODE);
  assign o_first_six_port_sel = first_six_sel[6:0];

  assign o_fifth_single_timer_bit = state_q.single_output_timer_route[4];
  assign o_fourth_single_timer_bit = state_q.single_output_timer_route[3];
  assign o_third_single_timer_bit = state_q.single_output_timer_route[2];
  assign o_second_single_timer_bit = state_q.single_output_timer_route[1];
  assign o_first_single_timer_bit = state_q.single_output_timer_route[0];

  // Four-output timer: bit n is code n (A, B, F, G); reserved codes select none.
  assign o_four_output_timer_field = state_q.four_output_timer_route[PPRR_FOUR_LSB +: 3];
  logic [7:0] four_sel;
  assign four_sel = pprr_onehot(o_four_output_timer_field, PPRR_FOUR_LAST_CODE);
  assign o_four_output_port_sel = four_sel[3:0];

  assign o_third_comparator_bit = state_q.comparator_output_route[2];
  assign o_second_comparator_bit = state_q.comparator_output_route[1];
  assign o_first_comparator_bit = state_q.comparator_output_route[0];

  assign o_third_zero_cross_bit = state_q.zero_cross_output_route[2];
  assign o_second_zero_cross_bit = state_q.zero_cross_output_route[1];
  assign o_first_zero_cross_bit = state_q.zero_cross_output_route[0];

  logic unused_upper;
  assign unused_upper = |{first_six_sel[7], second_six_sel[7:4], four_sel[7:4]};

endmodule

// ---- testbench/pprr_route_checker_sva.sv ----
// Concurrent checks on the routing register block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module pprr_route_checker
  import pprr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and register port.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [ADDR_W-1:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] o_reg_rdata,
  // Routing outputs.
  input wire logic [1:0] o_second_i2c_route_field,
  input wire logic [1:0] o_first_i2c_route_field,
  input wire logic o_second_i2c_client_alt,
  input wire logic [2:0] o_second_six_output_timer_field,
  input wire logic [2:0] o_first_six_output_timer_field,
  input wire logic [6:0] o_first_six_port_sel,
  input wire logic o_first_single_timer_bit,
  input wire logic [2:0] o_four_output_timer_field,
  input wire logic o_third_comparator_bit,
  input wire logic o_third_zero_cross_bit
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr(logic [7:0] a);
    i_reg_write && i_reg_addr == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    i_reg_read && i_reg_addr == a;
  endsequence
  chk_rdata_idle: assert property (!i_reg_read |=> o_reg_rdata == 8'h00)
    else $error("read data not idle");
  chk_i2c_write: assert property (s_wr(PPRR_I2C_ROUTE_OFFSET) |=>
    {o_second_i2c_route_field, o_first_i2c_route_field} == $past(i_reg_wdata[3:0]))
    else $error("i2c route not updated");
  chk_six_write: assert property (s_wr(PPRR_SIX_TIMER_ROUTE_OFFSET) |=>
    {o_second_six_output_timer_field, o_first_six_output_timer_field} == $past(i_reg_wdata[5:0]))
    else $error("six timer route not updated");
  chk_single_write: assert property (s_wr(PPRR_SINGLE_TIMER_ROUTE_OFFSET) |=>
    o_first_single_timer_bit == $past(i_reg_wdata[0])) else $error("single timer bit wrong");
  chk_four_write: assert property (s_wr(PPRR_FOUR_TIMER_ROUTE_OFFSET) |=>
    o_four_output_timer_field == $past(i_reg_wdata[2:0])) else $error("four timer route wrong");
  chk_comp_write: assert property (s_wr(PPRR_COMPARATOR_ROUTE_OFFSET) |=>
    o_third_comparator_bit == $past(i_reg_wdata[2])) else $error("comparator bit wrong");
  chk_zero_write: assert property (s_wr(PPRR_ZERO_CROSS_ROUTE_OFFSET) |=>
    o_third_zero_cross_bit == $past(i_reg_wdata[2])) else $error("zero cross bit wrong");
  chk_six_select: assert property (o_first_six_port_sel ==
    (o_first_six_output_timer_field == 3'h7 ? 7'h00 : 7'h01 << o_first_six_output_timer_field))
    else $error("six timer port select wrong");
  chk_client_alt: assert property (o_second_i2c_client_alt ==
    (o_second_i2c_route_field inside {2'h1, 2'h2})) else $error("i2c client position wrong");
  chk_read_back: assert property (s_rd(PPRR_SIX_TIMER_ROUTE_OFFSET) |=> o_reg_rdata ==
    {2'b00, $past(o_second_six_output_timer_field), $past(o_first_six_output_timer_field)})
    else $error("read back differs");
  chk_route_hold: assert property (!i_reg_write |=> $stable(o_four_output_timer_field))
    else $error("route changed without write");
endmodule

bind pprr_peripheral_pin_route_regs pprr_route_checker #(.ADDR_W(ADDR_W)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
  .o_second_i2c_route_field(o_second_i2c_route_field),
  .o_first_i2c_route_field(o_first_i2c_route_field),
  .o_second_i2c_client_alt(o_second_i2c_client_alt),
  .o_second_six_output_timer_field(o_second_six_output_timer_field),
  .o_first_six_output_timer_field(o_first_six_output_timer_field),
  .o_first_six_port_sel(o_first_six_port_sel), .o_first_single_timer_bit(o_first_single_timer_bit),
  .o_four_output_timer_field(o_four_output_timer_field),
  .o_third_comparator_bit(o_third_comparator_bit), .o_third_zero_cross_bit(o_third_zero_cross_bit));

// ---- testbench/testbench.sv ----
// Self-checking bench for the routing register block.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/100ps
module testbench;
  import pprr_pkg::*;
  localparam logic [7:0] MASKS [6] = '{PPRR_I2C_ROUTE_MASK, PPRR_SIX_TIMER_ROUTE_MASK,
    PPRR_SINGLE_TIMER_ROUTE_MASK, PPRR_FOUR_TIMER_ROUTE_MASK, PPRR_COMPARATOR_ROUTE_MASK,
    PPRR_ZERO_CROSS_ROUTE_MASK};
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_write = 1'b0;
  logic i_reg_read = 1'b0;
  logic [7:0] rdata;
  logic [1:0] i2c2, i2c1;
  logic h2, c2, v2, h1, c1, v1, all2;
  logic [2:0] six2, six1, four, cmp, zc;
  logic [3:0] sel2, fsel;
  logic [6:0] sel1;
  logic [4:0] sgl;
  logic [7:0] m [6] = '{default: 8'h00};
  logic [31:0] lfsr = 32'h591717d3;
  int fail_count = 0;
  int cmp_count = 0;
  always #12.5 i_sys_clk = ~i_sys_clk;
  pprr_peripheral_pin_route_regs dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write),
    .i_reg_read(i_reg_read), .o_reg_rdata(rdata), .o_second_i2c_route_field(i2c2),
    .o_first_i2c_route_field(i2c1), .o_second_i2c_host_alt(h2), .o_second_i2c_client_alt(c2),
    .o_second_i2c_route_valid(v2), .o_first_i2c_host_alt(h1), .o_first_i2c_client_alt(c1),
    .o_first_i2c_route_valid(v1), .o_second_six_output_timer_field(six2),
    .o_first_six_output_timer_field(six1), .o_second_six_port_sel(sel2),
    .o_second_six_all_outputs(all2), .o_first_six_port_sel(sel1),
    .o_fifth_single_timer_bit(sgl[4]), .o_fourth_single_timer_bit(sgl[3]),
    .o_third_single_timer_bit(sgl[2]), .o_second_single_timer_bit(sgl[1]),
    .o_first_single_timer_bit(sgl[0]), .o_four_output_timer_field(four),
    .o_four_output_port_sel(fsel), .o_third_comparator_bit(cmp[2]),
    .o_second_comparator_bit(cmp[1]), .o_first_comparator_bit(cmp[0]),
    .o_third_zero_cross_bit(zc[2]), .o_second_zero_cross_bit(zc[1]),
    .o_first_zero_cross_bit(zc[0]));
  // Codes above the last legal one select no port at all.
  function automatic logic [7:0] onehot(input logic [2:0] c, input logic [2:0] last);
    return c <= last ? 8'h01 << c : 8'h00;
  endfunction
  // Galois step of the stimulus generator; the fixed seed keeps runs repeatable.
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_write <= 1'b0;
    if (a inside {[8'h05:8'h0A]}) m[a-5] = d & MASKS[a-5];
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_sys_clk);
    i_reg_read <= 1'b0;
    #1 chk(rdata, a inside {[8'h05:8'h0A]} ? m[a-5] : 8'h00);
  endtask
  task automatic routes;
    #1;
    chk({i2c2, i2c1}, m[0][3:0]);
    chk({h2, c2, v2}, {m[0][3:2] == 2'h2, m[0][3:2] inside {2'h1, 2'h2}, m[0][3:2] != 2'h3});
    chk({h1, c1, v1}, {m[0][1:0] == 2'h2, m[0][1:0] inside {2'h1, 2'h2}, m[0][1:0] != 2'h3});
    chk({six2, six1}, m[1][5:0]);
    chk(sel1, onehot(m[1][2:0], 3'h6));
    chk({all2, sel2}, {m[1][5:3] == 3'h0 || m[1][5:3] == 3'h3, 4'(onehot(m[1][5:3], 3'h3))});
    chk(sgl, m[2][4:0]);
    chk({four, fsel}, {m[3][2:0], 4'(onehot(m[3][2:0], 3'h3))});
    chk(cmp, m[4][2:0]);
    chk(zc, m[5][2:0]);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #1ms;
    fail_count++;
    conclude;
  end
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int i = 5; i <= 10; i++) rd(8'(i));
    routes;
    $display("test reset values done");
    for (int i = 4; i <= 11; i++) begin
      wr(8'(i), 8'hFF);
      rd(8'(i));
    end
    rd(8'h00);
    routes;
    $display("test masks and unmapped done");
    for (int i = 0; i < 64; i++) begin
      wr(8'h05, 8'(i));
      wr(8'h06, 8'(i));
      wr(8'h08, 8'(i));
      routes;
    end
    $display("test all codes done");
    for (int i = 0; i < 300; i++) begin
      lfsr = lfsr_next(lfsr);
      if (lfsr[8]) wr(8'h04 + 8'(lfsr[2:0]), lfsr[23:16]);
      else rd(8'h04 + 8'(lfsr[2:0]));
      routes;
    end
    $display("test random traffic done");
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    m = '{default: 8'h00};
    rd(8'h06);
    routes;
    $display("test second reset done");
    conclude;
  end
endmodule
